// ### verilog/pia_top.sv
//
// Contract
// - identifier is 32 bits: organization id, model number, revision, over two registers
// - identifier may read as all zeros instead of a real code
// - offset 0x02 returns organization id bits 3..18, read-only
// - offset 0x03 bits 15:10 return organization id bits 19..24, read-only
// - offset 0x03 bits 9:4 hold fixed six-bit model number, msb at 9
// - offset 0x03 bits 3:0 hold fixed four-bit revision, msb at 3
// - offset 0x04 holds local abilities sent to link partner
// - bit 15 next-page request, read-write, resets 0
// - bit 14 reserved: writes ignored, reads 0
// - bit 13 remote-fault advertisement, read-write, resets 0
// - bit 12 reserved: software writes 0, reads back 0
// - bit 11 asymmetric pause, read-write, resets 0; resolution shown in control 13:12
// - bit 10 symmetric pause, read-write, resets 0
// - bit 9 four-pair ability fixed read-only 0
// - bits 8 and 7 fast abilities read-write, reset from straps
// - bits 6 and 5 ten abilities read-write
// - bits 4:0 selector read-write, resets 00001
// - status bit 5 reads 1 once negotiation completed, else 0
//
module pia_top #(
   parameter logic        ID_ZERO   = 1'b0,
   parameter logic [15:0] ORG_ID_HI = 16'h5A5A, // arbitrary
   parameter logic [5:0]  ORG_ID_LO = 6'h15,    // arbitrary
   parameter logic [5:0]  MODEL_NUM = 6'h2A,    // arbitrary
   parameter logic [3:0]  MODEL_REV = 4'h3      // arbitrary
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // management interface
   input  wire logic        mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe,
   // straps
   input  wire logic [4:0]  phy_addr,
   input  wire logic        strap_fast_full,
   input  wire logic        strap_fast_half,
   // negotiation side
   input  wire logic        an_complete,
   input  wire logic        an_restart,
   input  wire logic [1:0]  pause_res,
   output logic      [15:0] base_page
);
   pia_reg_if bus ();

   pia_pkg::pia_mdio_st_t st_q;
   pia_pkg::pia_mdio_st_t st_d;
   logic        mdc_q;
   logic        mdc_d;
   logic [5:0]  pre_q;
   logic [5:0]  pre_d;
   logic [4:0]  bcnt_q;
   logic [4:0]  bcnt_d;
   logic [12:0] hdr_q;
   logic [12:0] hdr_d;
   logic [12:0] hdr_full;
   logic [4:0]  reg_q;
   logic [4:0]  reg_d;
   logic [15:0] sh_q;
   logic [15:0] sh_d;
   logic        o_q;
   logic        o_d;
   logic        oe_q;
   logic        oe_d;
   logic        wr_q;
   logic        wr_d;
   logic [15:0] wdat_q;
   logic [15:0] wdat_d;
   logic        supp_q;
   logic        supp_d;
   logic [4:0]  phy_q;
   logic        mdc_rise;
   logic [15:0] adv;

   assign mdc_rise  = mdc && !mdc_q;
   assign hdr_full  = {hdr_q[11:0], mdio_i};
   assign bus.wr_en = wr_q;
   assign bus.addr  = reg_q;
   assign bus.wdata = wdat_q;
   assign mdio_o    = o_q;
   assign mdio_oe   = oe_q;

   always_comb begin
      mdc_d  = mdc;
      st_d   = st_q;
      pre_d  = pre_q;
      bcnt_d = bcnt_q;
      hdr_d  = hdr_q;
      reg_d  = reg_q;
      sh_d   = sh_q;
      o_d    = o_q;
      oe_d   = oe_q;
      wr_d   = 1'b0;
      wdat_d = wdat_q;
      supp_d = supp_q;
      if (mdc_rise) begin
         unique case (st_q)
            pia_pkg::PIA_IDLE: begin
               if (mdio_i) begin
                  if (pre_q != pia_pkg::PRE_LEN) begin
                     pre_d = pre_q + 6'h01;
                  end
               end else if (pre_q == pia_pkg::PRE_LEN || supp_q) begin
                  // first start bit; preamble needed only until the first read or write addressed to this device
                  st_d   = pia_pkg::PIA_HDR;
                  bcnt_d = 5'h00;
                  pre_d  = 6'h00;
               end else begin
                  pre_d = 6'h00;
               end
            end
            pia_pkg::PIA_HDR: begin
               hdr_d  = hdr_full;
               bcnt_d = bcnt_q + 5'h01;
               if (bcnt_q == pia_pkg::HDR_LAST) begin
                  bcnt_d = 5'h00;
                  st_d   = pia_pkg::PIA_IDLE;
                  if (hdr_full[12] && hdr_full[9:5] == phy_q) begin
                     reg_d = hdr_full[4:0];
                     if (hdr_full[11:10] == pia_pkg::OP_READ) begin
                        st_d   = pia_pkg::PIA_TA;
                        supp_d = 1'b1;
                     end else if (hdr_full[11:10] == pia_pkg::OP_WRITE) begin
                        st_d   = pia_pkg::PIA_WR;
                        supp_d = 1'b1;
                     end
                  end
               end
            end
            pia_pkg::PIA_TA: begin
               // second turnaround bit driven low
               oe_d   = 1'b1;
               o_d    = 1'b0;
               sh_d   = bus.rdata;
               bcnt_d = pia_pkg::DATA_BITS;
               st_d   = pia_pkg::PIA_RD;
            end
            pia_pkg::PIA_RD: begin
               if (bcnt_q != 5'h00) begin
                  o_d    = sh_q[15];
                  sh_d   = {sh_q[14:0], 1'b0};
                  bcnt_d = bcnt_q - 5'h01;
               end else begin
                  oe_d = 1'b0;
                  o_d  = 1'b0;
                  st_d = pia_pkg::PIA_IDLE;
               end
            end
            pia_pkg::PIA_WR: begin
               // two turnaround bits then sixteen data bits
               sh_d   = {sh_q[14:0], mdio_i};
               bcnt_d = bcnt_q + 5'h01;
               if (bcnt_q == pia_pkg::WR_LAST) begin
                  wr_d   = 1'b1;
                  wdat_d = {sh_q[14:0], mdio_i};
                  bcnt_d = 5'h00;
                  st_d   = pia_pkg::PIA_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         // follow the pin so a master resting mdc high gives no false edge
         mdc_q  <= mdc;
         st_q   <= pia_pkg::PIA_IDLE;
         pre_q  <= 6'h00;
         bcnt_q <= 5'h00;
         hdr_q  <= 13'h0000;
         reg_q  <= 5'h00;
         sh_q   <= 16'h0000;
         o_q    <= 1'b0;
         oe_q   <= 1'b0;
         wr_q   <= 1'b0;
         wdat_q <= 16'h0000;
         supp_q <= 1'b0;
         phy_q  <= phy_addr;
      end else begin
         mdc_q  <= mdc_d;
         st_q   <= st_d;
         pre_q  <= pre_d;
         bcnt_q <= bcnt_d;
         hdr_q  <= hdr_d;
         reg_q  <= reg_d;
         sh_q   <= sh_d;
         o_q    <= o_d;
         oe_q   <= oe_d;
         wr_q   <= wr_d;
         wdat_q <= wdat_d;
         supp_q <= supp_d;
         phy_q  <= phy_q;
      end
   end

   pia_adv_regs #(
      .ID_ZERO   (ID_ZERO),
      .ORG_ID_HI (ORG_ID_HI),
      .ORG_ID_LO (ORG_ID_LO),
      .MODEL_NUM (MODEL_NUM),
      .MODEL_REV (MODEL_REV)
   ) u_regs (
      .clk             (clk),
      .nrst            (nrst),
      .strap_fast_full (strap_fast_full),
      .strap_fast_half (strap_fast_half),
      .an_complete     (an_complete),
      .pause_res       (pause_res),
      .bus             (bus.slave),
      .adv_q           (adv)
   );

   pia_base_page u_page (
      .clk        (clk),
      .nrst       (nrst),
      .an_restart (an_restart),
      .adv        (adv),
      .page_q     (base_page)
   );
endmodule

// ### verilog/pia_pkg.sv
package pia_pkg;

   // register offsets on the management interface
   localparam logic [4:0] REG_STATUS   = 5'h01;
   localparam logic [4:0] REG_ID_HIGH  = 5'h02;
   localparam logic [4:0] REG_ID_LOW   = 5'h03;
   localparam logic [4:0] REG_ADVERT   = 5'h04;
   localparam logic [4:0] REG_PHY_CTRL = 5'h19;

   // advertisement field positions
   localparam int ADV_NEXT_PAGE    = 15;
   localparam int ADV_REMOTE_FAULT = 13;
   localparam int ADV_ASYM_PAUSE   = 11;
   localparam int ADV_SYM_PAUSE    = 10;
   localparam int ADV_FOUR_PAIR    = 9;
   localparam int ADV_FAST_FULL    = 8;
   localparam int ADV_FAST_HALF    = 7;
   localparam int ADV_TEN_FULL     = 6;
   localparam int ADV_TEN_HALF     = 5;

   // writable bits: 15,13,11,10,8:0 less bit 9
   localparam logic [15:0] ADV_WMASK   = 16'hADFF;
   localparam logic [4:0]  ADV_SEL_RST = 5'h01;
   localparam logic        ADV_TEN_RST = 1'b1;

   // status register: preamble suppression, autoneg able, extended capability
   localparam logic [15:0] STAT_FIXED   = 16'h0049;
   localparam int          STAT_AN_DONE = 5;
   localparam int          PCTL_PAUSE_LSB = 12;

   // management frame
   localparam logic [5:0] PRE_LEN   = 6'h20;
   localparam logic [1:0] OP_READ   = 2'h2;
   localparam logic [1:0] OP_WRITE  = 2'h1;
   localparam logic [4:0] HDR_LAST  = 5'h0C;
   localparam logic [4:0] WR_LAST   = 5'h11;
   localparam logic [4:0] DATA_BITS = 5'h10;

   typedef enum logic [2:0] {
      PIA_IDLE,
      PIA_HDR,
      PIA_TA,
      PIA_RD,
      PIA_WR
   } pia_mdio_st_t;

endpackage

// ### verilog/pia_reg_if.sv
interface pia_reg_if;
   logic        wr_en;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport master (
      output wr_en,
      output addr,
      output wdata,
      input  rdata
   );

   modport slave (
      input  wr_en,
      input  addr,
      input  wdata,
      output rdata
   );
endinterface

// ### verilog/pia_adv_regs.sv
module pia_adv_regs #(
   parameter logic        ID_ZERO   = 1'b0,
   parameter logic [15:0] ORG_ID_HI = 16'h5A5A, // arbitrary
   parameter logic [5:0]  ORG_ID_LO = 6'h15,    // arbitrary
   parameter logic [5:0]  MODEL_NUM = 6'h2A,    // arbitrary
   parameter logic [3:0]  MODEL_REV = 4'h3      // arbitrary
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // straps and status
   input  wire logic        strap_fast_full,
   input  wire logic        strap_fast_half,
   input  wire logic        an_complete,
   input  wire logic [1:0]  pause_res,
   // register access
   pia_reg_if.slave         bus,
   output logic      [15:0] adv_q
);
   localparam int ADV_FAST_FULL_IDX = pia_pkg::ADV_FAST_FULL;
   localparam int ADV_FAST_HALF_IDX = pia_pkg::ADV_FAST_HALF;

   logic [15:0] adv_d;
   logic [15:0] adv_rst;

   always_comb begin
      adv_rst = 16'h0000;
      adv_rst[ADV_FAST_FULL_IDX] = strap_fast_full;
      adv_rst[ADV_FAST_HALF_IDX] = strap_fast_half;
      adv_rst[pia_pkg::ADV_TEN_FULL] = pia_pkg::ADV_TEN_RST;
      adv_rst[pia_pkg::ADV_TEN_HALF] = pia_pkg::ADV_TEN_RST;
      adv_rst[4:0] = pia_pkg::ADV_SEL_RST;
      adv_d = adv_q;
      if (bus.wr_en && bus.addr == pia_pkg::REG_ADVERT) begin
         // reserved 14, 12 and fixed bit 9 never stored
         adv_d = bus.wdata & pia_pkg::ADV_WMASK;
      end
   end

   // straps caught by synchronous reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         adv_q <= adv_rst;
      end else begin
         adv_q <= adv_d;
      end
   end

   always_comb begin
      bus.rdata = 16'h0000;
      unique case (bus.addr)
         pia_pkg::REG_STATUS: begin
            bus.rdata = pia_pkg::STAT_FIXED;
            bus.rdata[pia_pkg::STAT_AN_DONE] = an_complete;
         end
         pia_pkg::REG_ID_HIGH: begin
            bus.rdata = ID_ZERO ? 16'h0000 : ORG_ID_HI;
         end
         pia_pkg::REG_ID_LOW: begin
            bus.rdata = ID_ZERO ? 16'h0000 : {ORG_ID_LO, MODEL_NUM, MODEL_REV};
         end
         pia_pkg::REG_ADVERT: begin
            bus.rdata = adv_q & pia_pkg::ADV_WMASK;
         end
         pia_pkg::REG_PHY_CTRL: begin
            bus.rdata[pia_pkg::PCTL_PAUSE_LSB +: 2] = pause_res;
         end
         default: begin
            bus.rdata = 16'h0000;
         end
      endcase
   end
endmodule

// ### verilog/pia_base_page.sv
module pia_base_page (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // control
   input  wire logic        an_restart,
   input  wire logic [15:0] adv,
   // page to transmit
   output logic      [15:0] page_q
);
   logic [15:0] page_d;
   logic        loaded_q;
   logic        loaded_d;

   always_comb begin
      page_d   = page_q;
      loaded_d = 1'b1;
      // first cycle after reset and every restart take a fresh copy
      if (an_restart || !loaded_q) begin
         page_d = adv;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         page_q   <= 16'h0000;
         loaded_q <= 1'b0;
      end else begin
         page_q   <= page_d;
         loaded_q <= loaded_d;
      end
   end
endmodule

// ### test/pia_top_sva.sv
module pia_top_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // management pins
   input wire logic        mdc,
   input wire logic        mdio_o,
   input wire logic        mdio_oe,
   // straps and page
   input wire logic        strap_fast_full,
   input wire logic        strap_fast_half,
   input wire logic        an_restart,
   input wire logic [15:0] base_page
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   page_reset_a: assert property (
      $rose(nrst) |=> base_page == {7'h00, $past(strap_fast_full), $past(strap_fast_half), 7'h61})
      else $error("base page reset value wrong");
   page_hold_a: assert property (
      $past(nrst) && !an_restart |=> $stable(base_page))
      else $error("base page moved without restart");
   page_fixed_a: assert property (
      base_page[14] == 1'b0 && base_page[12] == 1'b0 && base_page[9] == 1'b0)
      else $error("fixed page bit set");
   idle_reset_a: assert property (
      $rose(nrst) |-> !mdio_oe && !mdio_o)
      else $error("data pin active after reset");
   oe_edge_a: assert property (
      $changed(mdio_oe) |-> $past(mdc))
      else $error("enable changed away from clock rise");
   oe_hold_a: assert property (
      $rose(mdio_oe) |-> mdio_oe [*8])
      else $error("read drive too short");
   ta_zero_a: assert property (
      $rose(mdio_oe) |-> !mdio_o)
      else $error("turnaround bit not zero");
   oe_gap_a: assert property (
      $fell(mdio_oe) |-> !mdio_oe [*8])
      else $error("drive resumed too soon");
endmodule

bind pia_top pia_top_sva chk (
   .clk             (clk),
   .nrst            (nrst),
   .mdc             (mdc),
   .mdio_o          (mdio_o),
   .mdio_oe         (mdio_oe),
   .strap_fast_full (strap_fast_full),
   .strap_fast_half (strap_fast_half),
   .an_restart      (an_restart),
   .base_page       (base_page)
);

// ### test/pia_mgmt_model.sv
module pia_mgmt_model (
   // clock
   input  wire logic clk,
   // management pins
   output logic      mdc,
   output logic      mdio_i,
   input  wire logic mdio_o,
   input  wire logic mdio_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b0;
   logic bit_v = 1'b1;

   // released line floats high through the pull-up
   assign mdio_i = drv ? bit_v : (mdio_oe ? mdio_o : 1'b1);
   initial mdc = 1'b0;

   // one frame with full preamble; read bits taken from the line just before each rise
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] frm;
      frm = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 0; i < 65; i++) begin
         @(negedge clk);
         mdc <= 1'b0;
         drv <= (i < 46) || (i < 64 && op == 2'b01);
         bit_v <= (i < 64) ? frm[63 - i] : 1'b1;
         repeat (2) @(negedge clk);
         if (i >= 48 && i < 64) rd = {rd[14:0], mdio_i};
         mdc <= 1'b1;
         @(negedge clk);
      end
   endtask
endmodule

// ### test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ID_HI = 16'hC3A5; // arbitrary
   localparam logic [5:0]  ID_LO = 6'h2D;    // arbitrary
   localparam logic [5:0]  MNUM  = 6'h1B;    // arbitrary
   localparam logic [3:0]  MREV  = 4'h6;     // arbitrary
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        sff = 1'b0;
   logic        sfh = 1'b0;
   logic        anc = 1'b0;
   logic        anr = 1'b0;
   logic [4:0]  pa = 5'h00;
   logic [1:0]  pres = 2'h0;
   logic        mdc, mdio_i, mdio_o, mdio_oe;
   logic [15:0] page, rd, adv_m;
   logic        mdio_o_z, mdio_oe_z;
   logic [15:0] id_z = 16'hFFFF;
   int          err_total = 0;
   int          n_checks = 0;

   pia_top #(.ID_ZERO(1'b0), .ORG_ID_HI(ID_HI), .ORG_ID_LO(ID_LO), .MODEL_NUM(MNUM), .MODEL_REV(MREV)) uut (
      .clk(clk), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .phy_addr(pa), .strap_fast_full(sff), .strap_fast_half(sfh), .an_complete(anc),
      .an_restart(anr), .pause_res(pres), .base_page(page));
   pia_mgmt_model bfm (.clk(clk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
   // twin device with identifier forced to zero, listening to the same frames
   pia_top #(.ID_ZERO(1'b1)) uut_z (
      .clk(clk), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o_z), .mdio_oe(mdio_oe_z),
      .phy_addr(pa), .strap_fast_full(sff), .strap_fast_half(sfh), .an_complete(anc),
      .an_restart(anr), .pause_res(pres), .base_page());

   // twin's read data taken at the master's sampling edge
   always @(posedge mdc) begin
      if (mdio_oe_z) begin
         id_z <= {id_z[14:0], mdio_o_z};
      end
   end

   task automatic finish_test();
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] exp_rd(input logic [4:0] ra);
      case (ra)
         5'h01: return 16'h0049 | {10'h000, anc, 5'h00};
         5'h02: return ID_HI;
         5'h03: return {ID_LO, MNUM, MREV};
         5'h04: return adv_m;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      bfm.xfer(2'b01, pa, ra, d, rd);
      if (ra == 5'h04) adv_m = d & 16'hADFF;
   endtask

   task automatic rd_chk(input logic [4:0] ra);
      bfm.xfer(2'b10, pa, ra, 16'h0000, rd);
      check(rd, exp_rd(ra));
   endtask

   task automatic do_reset(input logic ff, input logic fh);
      @(negedge clk);
      nrst = 1'b0;
      sff = ff;
      sfh = fh;
      pa = 5'($urandom);
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      adv_m = {7'h00, ff, fh, 2'b11, 5'h01};
   endtask

   initial begin
      forever #20 clk = ~clk;
   end

   initial begin
      #3000000;
      err_total++;
      finish_test();
   end

   initial begin
      void'($urandom(32'hD0F75EBB));
      do_reset(1'b1, 1'b0);
      for (int r = 1; r < 5; r++) rd_chk(5'(r));
      anc = 1'b1;
      rd_chk(5'h01);
      rd_chk(5'h07);
      pres = 2'($urandom);
      bfm.xfer(2'b10, pa, 5'h19, 16'h0000, rd);
      check(rd, {2'b00, pres, 12'h000});
      wr(5'h02, 16'hFFFF);
      rd_chk(5'h02);
      check(id_z, 16'h0000);
      wr(5'h04, 16'hEFFF);
      rd_chk(5'h04);
      for (int k = 0; k < 6; k++) begin
         wr(5'h04, 16'($urandom) & 16'hEFFF);
         anr = 1'b1;
         @(negedge clk);
         anr = 1'b0;
         @(negedge clk);
         check(page, adv_m);
         rd_chk(5'h04);
      end
      bfm.xfer(2'b01, pa ^ 5'h01, 5'h04, 16'h0000, rd);
      rd_chk(5'h04);
      wr(5'h04, 16'h0000);
      rd_chk(5'h04);
      do_reset(1'($urandom), 1'($urandom));
      anc = 1'b0;
      rd_chk(5'h04);
      rd_chk(5'h01);
      rd_chk(5'h03);
      check(id_z, 16'h0000);
      finish_test();
   end
endmodule
